/* File: common/srctl_pkg.sv */
// System reset controller: constants, register indices, reset values, types.
// Assumes one 50 MHz system clock and AXI4-Lite register access.
package srctl_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int PIN_FILT_NS = 32000;
	localparam int PIN_FILT_CYC = (PIN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = 16;
	localparam int NREG = 16;
	localparam int AW = 8;
	// Register indices, byte address is index times four
	localparam logic [3:0] IX_FLAGS = 4'h0, IX_IPRST = 4'h1, IX_CLK = 4'h2, IX_PWR = 4'h3;
	localparam logic [3:0] IX_BOD = 4'h4, IX_SRAML = 4'h5, IX_SRAMU = 4'h6, IX_CLKST = 4'h7;
	localparam logic [3:0] IX_PLL = 4'h8, IX_MISC = 4'h9, IX_WDT = 4'hA, IX_WALT = 4'hB;
	localparam logic [3:0] IX_WWCTL = 4'hC, IX_WWRLD = 4'hD, IX_WWST = 4'hE, IX_WWCNT = 4'hF;
	// Cause flag positions
	localparam int FLG_POR = 0, FLG_PIN = 1, FLG_WDT = 2, FLG_LVR = 3;
	localparam int FLG_BOD = 4, FLG_SYS = 5, FLG_CPU = 7, FLG_LOCK = 8;
	// Field positions
	localparam int IP_CHIP = 0, IP_CPU = 1;
	localparam int CLK_SEL_LSB = 0, CLK_DIV_LSB = 4;
	localparam int PL_LSB = 8, REG_TYPE = 12;
	localparam int BOD_EN = 0, BOD_WATCHDOG_RESET_ENABLE = 3, BOD_LVL_LSB = 16;
	localparam int CFG_WDTRST = 3, CFG_WATCHDOG_ENABLE = 4, CFG_BROWNOUT_ENABLE = 19, CFG_BORST = 20, CFG_BOV_LSB = 21;
	localparam int KS_LSB = 28, PKE_LSB = 26;
	localparam int LOW_SPEED_CRYSTAL_STABLE = 1;
	localparam int WCKEN = 0, LOW_SPEED_CRYSTAL_ENABLE = 1, PDM_LSB = 4, WSEL_LSB = 8;
	localparam int WDT_WATCHDOG_RESET_ENABLE = 1, WDT_EN = 7;
	// Reset values
	localparam logic [2:0] CLK_FULL_SEL = 3'h5, CLK_SYS_SEL = 3'h6;
	localparam logic [3:0] CLK_FULL_DIV = 4'h0, CLK_SYS_DIV = 4'h3;
	localparam logic [1:0] PL_RST = 2'h2, KS_RST = 2'h0, PKE_RST = 2'h2, WSEL_RST = 2'h3;
	localparam logic [31:0] SRAML_POR = 32'h0080_0000;
	localparam logic [31:0] CLKST_CLR = 32'h0000_0095;
	localparam logic [31:0] PLL_RST = 32'h0000_940A;
	localparam logic [31:0] WATCHDOG_CONTROL_RST = 32'h0000_0800;
	localparam logic [31:0] WINDOW_WATCHDOG_CONTROL_RST = 32'h003F_0800;
	localparam logic [31:0] WINDOW_WATCHDOG_COUNTER_RST = 32'h0000_003F;
	localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		SRC_POR = 4'h0, SRC_PIN = 4'h1, SRC_WDT = 4'h2, SRC_LVR = 4'h3, SRC_BOD = 4'h4,
		SRC_LOCK = 4'h5, SRC_CHIP = 4'h6, SRC_SYS = 4'h7, SRC_CPU = 4'h8
	} srctl_src_t;

	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_HOLD = 1'b1
	} srctl_state_t;

	typedef struct packed {
		logic wdt;
		logic lvr;
		logic bod;
		logic lockup;
		logic sysreq;
	} srctl_ev_t;
endpackage : srctl_pkg

/* File: rtl/srctl_top.sv */
// System reset controller: source arbitration, pin glitch filter, per-source
// retention policy, sticky cause flags and an AXI4-Lite register slave.
// Assumes detector and core request inputs are synchronous to core_clk_i.
`timescale 1ns/1ps
module srctl_top
	import srctl_pkg::*;
(
	// Clock and power-on reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Reset sources
	input wire logic external_reset_pin_n_i,
	input wire srctl_ev_t src_ev_i,
	input wire logic debug_mode_i,
	input wire logic [31:0] user_configuration_word_i,
	input wire logic [31:0] clk_status_set_i,
	// Reset outputs and retained state
	output logic core_reset_o,
	output logic periph_reset_o,
	output logic [NREG-1:0][31:0] ctrl_regs_o,
	// AXI4-Lite slave
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

////////////////////////////////////////////////////////////////////////////////

	function automatic logic reg_hit(input logic [AW-1:0] a);
		reg_hit = (a[AW-1:6] == '0);
	endfunction : reg_hit

	function automatic logic reg_writable(input logic [3:0] ix);
		reg_writable = !(ix inside {IX_FLAGS, IX_IPRST, IX_PWR, IX_CLKST});
	endfunction : reg_writable

	// New value of one register after a reset from source s
	function automatic logic [31:0] policy(input srctl_src_t s, input logic [3:0] ix,
		input logic [31:0] v, input logic [31:0] cfg);
		logic full;
		logic por;
		logic keep;
		full = s inside {SRC_POR, SRC_PIN, SRC_WDT, SRC_LVR, SRC_BOD, SRC_CHIP};
		por = (s == SRC_POR);
		keep = (s == SRC_CPU);
		policy = v;
		case (ix)
			IX_IPRST: begin
				if (por) policy[IP_CHIP] = 1'b0;
				policy[IP_CPU] = 1'b0;
			end
			IX_CLK: begin
				if (full) begin
					policy[CLK_SEL_LSB +: 3] = CLK_FULL_SEL;
					policy[CLK_DIV_LSB +: 4] = CLK_FULL_DIV;
				end else if (!keep) begin
					policy[CLK_SEL_LSB +: 3] = CLK_SYS_SEL;
					policy[CLK_DIV_LSB +: 4] = CLK_SYS_DIV;
				end
			end
			IX_PWR: begin
				if (full) policy[PL_LSB +: 2] = PL_RST;
				if (por) policy[REG_TYPE] = 1'b0;
			end
			IX_BOD: begin
				if (!keep && s != SRC_BOD) begin
					policy[BOD_EN] = cfg[CFG_BROWNOUT_ENABLE];
					policy[BOD_WATCHDOG_RESET_ENABLE] = cfg[CFG_BORST];
					policy[BOD_LVL_LSB +: 3] = cfg[CFG_BOV_LSB +: 3];
				end
			end
			IX_SRAML: begin
				if (por) policy = SRAML_POR;
				if (full) begin
					policy[KS_LSB +: 2] = KS_RST;
					policy[PKE_LSB +: 2] = PKE_RST;
				end
			end
			IX_SRAMU: if (por) policy = '0;
			IX_CLKST: begin
				if (!keep) policy = v & ~CLKST_CLR;
				if (por) policy[LOW_SPEED_CRYSTAL_STABLE] = 1'b0;
			end
			IX_PLL: if (!keep) policy = PLL_RST;
			IX_MISC: begin
				if (por || s == SRC_WDT || s == SRC_CHIP) policy[WCKEN] = 1'b1;
				if (por || s == SRC_PIN) policy[WSEL_LSB +: 2] = WSEL_RST;
				if (por) begin
					policy[LOW_SPEED_CRYSTAL_ENABLE] = 1'b0;
					policy[PDM_LSB +: 3] = 3'h0;
				end
			end
			IX_WDT: begin
				if (full) policy = WATCHDOG_CONTROL_RST;
				if (full || s == SRC_LOCK) begin
					policy[WDT_EN] = cfg[CFG_WATCHDOG_ENABLE];
					policy[WDT_WATCHDOG_RESET_ENABLE] = cfg[CFG_WDTRST];
				end
			end
			IX_WALT, IX_WWRLD, IX_WWST: if (full) policy = '0;
			IX_WWCTL: if (full) policy = WINDOW_WATCHDOG_CONTROL_RST;
			IX_WWCNT: if (full) policy = WINDOW_WATCHDOG_COUNTER_RST;
			default: policy = v;
		endcase
	endfunction : policy

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser and glitch filter

	logic pin_s1_q, pin_s2_q, pin_filt_q, pin_filt_d;
	logic [10:0] pin_cnt_q, pin_cnt_d;

	always_comb begin
		pin_filt_d = pin_filt_q;
		pin_cnt_d = '0;
		if (pin_s2_q != pin_filt_q) begin
			if (pin_cnt_q == 11'(PIN_FILT_CYC)) pin_filt_d = pin_s2_q;
			else pin_cnt_d = pin_cnt_q + 11'd1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_filt_q <= 1'b1;
			pin_cnt_q <= '0;
		end else begin
			pin_s1_q <= external_reset_pin_n_i;
			pin_s2_q <= pin_s1_q;
			pin_filt_q <= pin_filt_d;
			pin_cnt_q <= pin_cnt_d;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Reset sequencer

	srctl_state_t state_q, state_d;
	srctl_src_t src_q, src_d;
	logic apply_q, apply_d;
	logic [4:0] hold_cnt_q, hold_cnt_d;
	logic chip_req_q, chip_req_d, cpu_req_q, cpu_req_d;
	logic [NREG-1:0][31:0] regs_q, regs_d;
	logic [AW-1:0] aw_a_q, ar_ix_a;
	logic aw_v_q, w_v_q, bvalid_q, rvalid_q, wr_fire;
	logic [31:0] w_d_q, rdata_q, wr_mask;
	logic [3:0] w_s_q, wr_ix;
	logic [1:0] bresp_q, rresp_q;

	always_comb begin
		state_d = state_q;
		src_d = src_q;
		apply_d = 1'b0;
		hold_cnt_d = hold_cnt_q;
		chip_req_d = chip_req_q;
		cpu_req_d = cpu_req_q;
		if (wr_fire && reg_hit(aw_a_q) && wr_ix == IX_IPRST) begin
			chip_req_d = chip_req_q | (w_d_q[IP_CHIP] & wr_mask[IP_CHIP]);
			cpu_req_d = cpu_req_q | (w_d_q[IP_CPU] & wr_mask[IP_CPU]);
		end
		case (state_q)
			ST_RUN: begin
				state_d = ST_HOLD;
				apply_d = 1'b1;
				hold_cnt_d = '0;
				if (!pin_filt_q) src_d = SRC_PIN;
				else if (src_ev_i.wdt) src_d = SRC_WDT;
				else if (src_ev_i.lvr) src_d = SRC_LVR;
				else if (src_ev_i.bod) src_d = SRC_BOD;
				else if (src_ev_i.lockup && !debug_mode_i) src_d = SRC_LOCK;
				else if (chip_req_q) src_d = SRC_CHIP;
				else if (src_ev_i.sysreq) src_d = SRC_SYS;
				else if (cpu_req_q) src_d = SRC_CPU;
				else begin
					state_d = ST_RUN;
					apply_d = 1'b0;
				end
				if (state_d == ST_HOLD) begin
					chip_req_d = 1'b0;
					cpu_req_d = 1'b0;
				end
			end
			ST_HOLD: begin
				if (hold_cnt_q != 5'(HOLD_CYC - 1)) hold_cnt_d = hold_cnt_q + 5'd1;
				else if (!(src_q == SRC_PIN && !pin_filt_q)) state_d = ST_RUN;
			end
			default: state_d = ST_HOLD;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_q <= ST_HOLD;
			src_q <= SRC_POR;
			apply_q <= 1'b1;
			hold_cnt_q <= '0;
			chip_req_q <= 1'b0;
			cpu_req_q <= 1'b0;
		end else begin
			state_q <= state_d;
			src_q <= src_d;
			apply_q <= apply_d;
			hold_cnt_q <= hold_cnt_d;
			chip_req_q <= chip_req_d;
			cpu_req_q <= cpu_req_d;
		end
	end

	// Core-only reset leaves peripherals running
	assign core_reset_o = reset_i | (state_q == ST_HOLD);
	assign periph_reset_o = reset_i | (state_q == ST_HOLD && src_q != SRC_CPU);

////////////////////////////////////////////////////////////////////////////////
// Registers: writes, then reset policy, then hardware sets (set wins)

	for (genvar b = 0; b < 4; b++) begin : g_mask
		assign wr_mask[8*b +: 8] = {8{w_s_q[b]}};
	end

	assign wr_fire = aw_v_q & w_v_q & ~bvalid_q;
	assign wr_ix = aw_a_q[5:2];

	always_comb begin
		regs_d = regs_q;
		if (wr_fire && reg_hit(aw_a_q)) begin
			if (wr_ix == IX_FLAGS) begin
				regs_d[IX_FLAGS] = regs_q[IX_FLAGS] & ~(w_d_q & wr_mask);
			end else if (wr_ix == IX_IPRST) begin
				regs_d[IX_IPRST][IP_CHIP] = regs_q[IX_IPRST][IP_CHIP] | (w_d_q[IP_CHIP] & wr_mask[IP_CHIP]);
			end else if (reg_writable(wr_ix)) begin
				regs_d[wr_ix] = (regs_q[wr_ix] & ~wr_mask) | (w_d_q & wr_mask);
			end
		end
		if (state_q == ST_HOLD && apply_q) begin
			for (int i = 1; i < NREG; i++) begin
				regs_d[i] = policy(src_q, 4'(i), regs_d[i], user_configuration_word_i);
			end
			case (src_q)
				SRC_POR, SRC_CHIP: regs_d[IX_FLAGS][FLG_POR] = 1'b1;
				SRC_PIN: regs_d[IX_FLAGS][FLG_PIN] = 1'b1;
				SRC_WDT: regs_d[IX_FLAGS][FLG_WDT] = 1'b1;
				SRC_LVR: regs_d[IX_FLAGS][FLG_LVR] = 1'b1;
				SRC_BOD: regs_d[IX_FLAGS][FLG_BOD] = 1'b1;
				SRC_SYS: regs_d[IX_FLAGS][FLG_SYS] = 1'b1;
				SRC_CPU: regs_d[IX_FLAGS][FLG_CPU] = 1'b1;
				SRC_LOCK: regs_d[IX_FLAGS][FLG_LOCK] = 1'b1;
				default: regs_d[IX_FLAGS] = regs_d[IX_FLAGS];
			endcase
		end
		regs_d[IX_CLKST] = regs_d[IX_CLKST] | clk_status_set_i;
	end

	// Flags are cleared only by power-on or by writing ones to them; other sources must not erase history
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			regs_q <= '0;
		end else begin
			regs_q <= regs_d;
		end
	end

	assign ctrl_regs_o = regs_q;

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

	assign s_axi_awready_o = ~aw_v_q & ~bvalid_q;
	assign s_axi_wready_o = ~w_v_q & ~bvalid_q;
	assign s_axi_arready_o = ~rvalid_q;
	assign ar_ix_a = s_axi_araddr_i;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			aw_v_q <= 1'b0;
			w_v_q <= 1'b0;
			aw_a_q <= '0;
			w_d_q <= '0;
			w_s_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_v_q <= 1'b1;
				aw_a_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_v_q <= 1'b1;
				w_d_q <= s_axi_wdata_i;
				w_s_q <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_v_q <= 1'b0;
				w_v_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= reg_hit(aw_a_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				rvalid_q <= 1'b1;
				rdata_q <= reg_hit(ar_ix_a) ? regs_q[ar_ix_a[5:2]] : '0;
				rresp_q <= reg_hit(ar_ix_a) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready_i) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

////////////////////////////////////////////////////////////////////////////////
// Assertions

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_enter(srctl_src_t s);
		state_q == ST_HOLD && apply_q && src_q == s;
	endsequence

	a_pin_filter_fall: assert property ($fell(pin_filt_q) |-> $past(pin_cnt_q) == 11'(PIN_FILT_CYC))
		else $error("pin filter fell early");
	a_pin_hold_release: assert property (state_q == ST_HOLD && src_q == SRC_PIN && !pin_filt_q
		|=> state_q == ST_HOLD)
		else $error("pin reset released while pin low");
	a_pin_flag_set: assert property (s_enter(SRC_PIN) |=> regs_q[IX_FLAGS][FLG_PIN])
		else $error("pin flag not set");
	a_core_only_keeps: assert property (s_enter(SRC_CPU) |-> core_reset_o && !periph_reset_o
		##1 regs_q[IX_PLL] == $past(regs_q[IX_PLL]))
		else $error("core-only reset touched peripherals");
	a_chip_req_taken: assert property (chip_req_q && state_q == ST_RUN |=> state_q == ST_HOLD
		##0 periph_reset_o)
		else $error("chip request not taken");
	a_lockup_debug: assert property ($rose(state_q == ST_HOLD) && src_q == SRC_LOCK
		|-> !$past(debug_mode_i))
		else $error("lockup reset in debug mode");
	a_sys_clock_sel: assert property (s_enter(SRC_SYS) |=> regs_q[IX_CLK][CLK_SEL_LSB +: 3] == CLK_SYS_SEL
		&& regs_q[IX_CLK][CLK_DIV_LSB +: 4] == CLK_SYS_DIV)
		else $error("system reset clock select wrong");
	a_pll_reload: assert property (state_q == ST_HOLD && apply_q && src_q != SRC_CPU
		|=> regs_q[IX_PLL] == PLL_RST)
		else $error("pll control not reset");
	a_flag_sticky: assert property (!(wr_fire && wr_ix == IX_FLAGS)
		|=> (regs_q[IX_FLAGS] & $past(regs_q[IX_FLAGS])) == $past(regs_q[IX_FLAGS]))
		else $error("cause flag lost without clear");
endmodule : srctl_top

/* File: verification/srctl_src_model.sv */
// Far-side model: reset pin, source requests, debug flag, config word, clock status.
// Assumes the bench calls its tasks from one thread only.
`timescale 1ns/1ps
module srctl_src_model
	import srctl_pkg::*;
(
	// Clock
	input wire logic core_clk_i,
	// Source side
	output logic pin_n_o,
	output srctl_ev_t ev_o,
	output logic debug_o,
	output logic [31:0] cfg_o,
	output logic [31:0] clkst_o
);
	initial begin
		pin_n_o = 1'b1;
		ev_o = '0;
		debug_o = 1'b0;
		cfg_o = 32'h00B8_0018;
		clkst_o = 32'h0000_0000;
	end
	////////////////////////////////////////////////////////////////////////////
	// Pin low for n cycles, then back high
	task automatic pin_low(input int n);
		@(posedge core_clk_i);
		pin_n_o <= 1'b0;
		repeat (n) @(posedge core_clk_i);
		pin_n_o <= 1'b1;
	endtask : pin_low
	// One-cycle pulse, so a level source cannot re-trigger after the hold
	task automatic pulse(input srctl_ev_t e);
		@(posedge core_clk_i);
		ev_o <= e;
		@(posedge core_clk_i);
		ev_o <= '0;
	endtask : pulse
	task automatic set_misc(input logic dbg, input logic [31:0] cs);
		@(posedge core_clk_i);
		debug_o <= dbg;
		clkst_o <= cs;
	endtask : set_misc
endmodule : srctl_src_model

/* File: verification/srctl_top_tb.sv */
// Testbench for the reset controller: AXI4-Lite tasks and reset-source scenarios.
// Assumes the source model drives all far-side inputs.
`timescale 1ns/1ps
module srctl_top_tb
	import srctl_pkg::*;
;
	localparam int TMO = 20000;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic pin_n, dbg, core_rst, per_rst;
	srctl_ev_t ev;
	logic [31:0] cfg, cs;
	logic [NREG-1:0][31:0] regs;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic ph;
	int len, cyc = 0, n_errors = 0, n_checks = 0;
	logic [7:0] pa [8] = '{8'h20, 8'h30, 8'h3C, 8'h10, 8'h28, 8'h14, 8'h24, 8'h0C};
	logic [31:0] pe [8] = '{PLL_RST, WINDOW_WATCHDOG_CONTROL_RST, WINDOW_WATCHDOG_COUNTER_RST, 32'h0005_0009, 32'h0000_0882,
		32'h0880_0000, 32'h0000_0301, 32'h0000_0200};

	always #10 core_clk_i = ~core_clk_i;

	srctl_src_model model (.core_clk_i(core_clk_i), .pin_n_o(pin_n), .ev_o(ev), .debug_o(dbg),
		.cfg_o(cfg), .clkst_o(cs));

	srctl_top dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .external_reset_pin_n_i(pin_n),
		.src_ev_i(ev), .debug_mode_i(dbg), .user_configuration_word_i(cfg), .clk_status_set_i(cs),
		.core_reset_o(core_rst), .periph_reset_o(per_rst), .ctrl_regs_o(regs),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	// Hang guard
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == TMO) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////////
	// Handshakes judged at the falling edge, where the combinational readies have settled
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge core_clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hb) begin
			@(negedge core_clk_i);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			rs = bresp;
			@(posedge core_clk_i);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ha, h;
		h = 1'b0;
		@(posedge core_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!h) begin
			@(negedge core_clk_i);
			ha = arvalid && arready;
			h = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge core_clk_i);
			if (ha) arvalid <= 1'b0;
			if (h) rready <= 1'b0;
		end
	endtask : rd

	// Length of the next core reset; zero if none starts within lim cycles
	task automatic wait_rst(input int lim, output int n_hi, output logic p);
		int n;
		n = 0;
		n_hi = 0;
		p = 1'b0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (core_rst !== 1'b1 && n < lim);
		while (core_rst === 1'b1) begin
			p = p | (per_rst === 1'b1);
			n_hi++;
			@(negedge core_clk_i);
		end
	endtask : wait_rst

	// Wait out a reset, then check cause flags and clock setting
	task automatic after(input int b, input logic [31:0] ck, input logic eph, output int n_hi);
		logic p;
		logic [31:0] v;
		logic [1:0] rs;
		wait_rst(60, n_hi, p);
		chk({31'h0, p}, {31'h0, eph});
		wr(8'h00, 32'h0000_0000, rs);
		rd(8'h00, v, rs);
		chk(v, 32'h0000_0001 << b);
		wr(8'h00, 32'h0000_01FF, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		rd(8'h00, v, rs);
		chk(v, 32'h0000_0000);
		rd(8'h08, v, rs);
		chk(v, ck);
		wr(8'h08, 32'h0000_0012, rs);
	endtask : after

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk_i);
		reset_i <= 1'b0;
		after(FLG_POR, 32'h0000_0005, 1'b1, len);
		wr(8'h0C, 32'hFFFF_FFFF, r);
		for (int i = 0; i < 8; i++) begin
			rd(pa[i], d, r);
			chk(d, pe[i]);
			chk(regs[pa[i][5:2]], pe[i]);
		end
		rd(8'h40, d, r);
		chk(d, 32'h0000_0000);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h80, 32'h0000_0001, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		for (int k = 0; k < 3; k++) begin
			model.pulse(srctl_ev_t'(5'h10 >> k));
			after(FLG_WDT + k, 32'h0000_0005, 1'b1, len);
		end
		wr(8'h10, 32'h0000_0000, r);
		wr(8'h28, 32'h0000_0000, r);
		model.set_misc(1'b0, 32'h0000_0097);
		model.set_misc(1'b0, 32'h0000_0000);
		model.pulse(srctl_ev_t'(5'h04));
		after(FLG_BOD, 32'h0000_0005, 1'b1, len);
		rd(8'h10, d, r);
		chk(d, 32'h0000_0000);
		rd(8'h28, d, r);
		chk(d, 32'h0000_0882);
		rd(8'h1C, d, r);
		chk(d, 32'h0000_0002);
		model.set_misc(1'b1, 32'h0000_0000);
		model.pulse(srctl_ev_t'(5'h02));
		wait_rst(40, len, ph);
		chk(32'(len), 32'h0000_0000);
		model.set_misc(1'b0, 32'h0000_0000);
		model.pulse(srctl_ev_t'(5'h02));
		after(FLG_LOCK, 32'h0000_0036, 1'b1, len);
		model.pulse(srctl_ev_t'(5'h01));
		after(FLG_SYS, 32'h0000_0036, 1'b1, len);
		wr(8'h04, 32'h0000_0002, r);
		after(FLG_CPU, 32'h0000_0012, 1'b0, len);
		wr(8'h04, 32'h0000_0001, r);
		after(FLG_POR, 32'h0000_0005, 1'b1, len);
		chk({31'h0, len >= HOLD_CYC}, 32'h0000_0001);
		rd(8'h04, d, r);
		chk(d & 32'h0000_0001, 32'h0000_0001);
		model.pin_low(1500);
		wait_rst(40, len, ph);
		chk(32'(len), 32'h0000_0000);
		model.pin_low(1700);
		after(FLG_PIN, 32'h0000_0005, 1'b1, len);
		chk({31'h0, len > PIN_FILT_CYC}, 32'h0000_0001);
		end_of_test();
	end
endmodule : srctl_top_tb
